// ==== rtl/tks_touch_key_status_regs.sv ====
// Register file, serial slave and key event logic of the touch-key block.
`timescale 1ns/1ps
`default_nettype none
module tks_touch_key_status_regs
  import tks_pkg::*;
#(
  parameter int TICK_CYCLES = TKS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial bus, data line open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps and pins
  input wire logic [1:0] addr_sel,
  input wire logic hw_shutdown_n,
  // Sensing front end
  input wire logic [7:0] key_raw,
  output logic [1:0] sens_sel,
  output logic [7:0] ch_active,
  // Outputs
  output logic irq_out_n,
  output logic [7:0] key_out_n
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  tks_state_t s_r;
  tks_state_t s_nxt;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic sd_any, wr_ok, rd_clr, auto_rel, irq_new;
  logic [7:0] ev;
  logic [7:0] rd_data;
  logic [7:0] rd_sel;
  logic [5:0] ms_lim;

  assign scl_rise = scl_i & ~s_r.scl_q;
  assign scl_fall = ~scl_i & s_r.scl_q;
  assign bus_start = scl_i & s_r.scl_q & s_r.sda_q & ~sda_i;
  assign bus_stop = scl_i & s_r.scl_q & ~s_r.sda_q & sda_i;
  assign sd_any = ~hw_shutdown_n | s_r.cfg[TKS_SSD_BIT];
  // writes held off in hardware shutdown
  assign wr_ok = hw_shutdown_n;
  // only enabled, running channels produce events
  assign ev = (key_raw ^ s_r.pressed) & s_r.chen & {8{~sd_any}};
  // sensitivity field drives the front end
  assign sens_sel = s_r.cfg[TKS_SENS_HI:TKS_SENS_LO];
  assign ch_active = s_r.chen & {8{~sd_any}};
  assign sda_o = 1'b0;
  assign sda_oe = s_r.sda_oe;
  assign irq_out_n = s_r.irq_n;
  assign key_out_n = ~s_r.pressed;

  always_comb begin
    unique case (s_r.regaddr)
      TKS_OFS_CFG: rd_sel = s_r.cfg;
      TKS_OFS_CHEN: rd_sel = s_r.chen;
      TKS_OFS_PRESSED: rd_sel = s_r.pressed;
      TKS_OFS_CHANGE: rd_sel = s_r.change;
      TKS_OFS_IRQ: rd_sel = s_r.irqc;
      default: rd_sel = 8'h00;
    endcase
  end
  assign rd_data = rd_sel;
  // load of the change register for reading clears it
  assign rd_clr = scl_fall & s_r.regaddr == TKS_OFS_CHANGE &
    ((s_r.st == TKS_ACK_A & s_r.rw) | s_r.st == TKS_RACK);
  // an invalid code 11 behaves as no auto clear
  assign ms_lim = (s_r.irqc[TKS_ACI_HI:TKS_ACI_LO] == TKS_ACI_SHORT) ?
    TKS_SHORT_MS : TKS_LONG_MS;
  assign auto_rel = ~s_r.irq_n & s_r.ms_cnt == ms_lim &
    (s_r.irqc[TKS_ACI_HI:TKS_ACI_LO] == TKS_ACI_SHORT |
     s_r.irqc[TKS_ACI_HI:TKS_ACI_LO] == TKS_ACI_LONG);
  assign irq_new = s_r.irq_n & (|ev);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_q = scl_i;
    s_nxt.sda_q = sda_i;
    // The strap is caught after reset release, never by the reset itself.
    if (!s_r.strap_done) begin
      s_nxt.addr_sel = addr_sel;
      s_nxt.strap_done = 1'b1;
    end
    unique case (s_r.st)
      TKS_IDLE: begin
      end
      TKS_ADDR, TKS_REG, TKS_WDATA: begin
        // bytes arrive most significant bit first
        if (scl_rise) begin
          s_nxt.shift = {s_r.shift[6:0], sda_i};
          s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
        end
        if (scl_fall && s_r.bitcnt == 4'h8) begin
          s_nxt.sda_oe = 1'b1;
          s_nxt.bitcnt = 4'h0;
          if (s_r.st == TKS_ADDR) begin
            // match the fixed pattern and strap bits
            if (s_r.shift[7:1] == {TKS_ADDR_UPPER, s_r.addr_sel}) begin
              s_nxt.rw = s_r.shift[0];
              s_nxt.st = TKS_ACK_A;
            end else begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.st = TKS_IDLE;
            end
          end else if (s_r.st == TKS_REG) begin
            s_nxt.regaddr = s_r.shift;
            s_nxt.st = TKS_ACK_R;
          end else begin
            // data byte written to the addressed register when it is CFG, CHEN or IRQ
            if (wr_ok && s_r.regaddr == TKS_OFS_CFG) begin
              s_nxt.cfg = s_r.shift & 8'he0;
            end
            if (wr_ok && s_r.regaddr == TKS_OFS_CHEN) begin
              s_nxt.chen = s_r.shift;
            end
            if (wr_ok && s_r.regaddr == TKS_OFS_IRQ) begin
              s_nxt.irqc = s_r.shift & 8'hc0;
            end
            s_nxt.st = TKS_ACK_W;
          end
        end
      end
      TKS_ACK_A, TKS_RACK: begin
        // A read that the master refuses ends the transfer.
        if (s_r.st == TKS_RACK && scl_rise && sda_i) begin
          s_nxt.st = TKS_IDLE;
        end else if (scl_fall) begin
          s_nxt.bitcnt = 4'h0;
          if (s_r.rw) begin
            // returned data starts on the falling edge
            s_nxt.shift = rd_data;
            s_nxt.sda_oe = ~rd_data[7];
            s_nxt.st = TKS_RDATA;
          end else begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.st = TKS_REG;
          end
        end
      end
      TKS_ACK_R, TKS_ACK_W: begin
        if (scl_fall) begin
          s_nxt.sda_oe = 1'b0;
          s_nxt.bitcnt = 4'h0;
          s_nxt.st = TKS_WDATA;
        end
      end
      TKS_RDATA: begin
        if (scl_rise) begin
          s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
        end
        if (scl_fall && s_r.bitcnt == 4'h8) begin
          s_nxt.sda_oe = 1'b0;
          s_nxt.st = TKS_RACK;
        end else if (scl_fall) begin
          s_nxt.shift = {s_r.shift[6:0], 1'b0};
          s_nxt.sda_oe = ~s_r.shift[6];
        end
      end
      default: begin
        s_nxt.st = TKS_IDLE;
        s_nxt.sda_oe = 1'b0;
      end
    endcase
    if (bus_start) begin
      s_nxt.st = TKS_ADDR;
      s_nxt.bitcnt = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (bus_stop) begin
      s_nxt.st = TKS_IDLE;
      s_nxt.sda_oe = 1'b0;
    end
    s_nxt.pressed = s_r.pressed ^ ev;
    // a new event wins over the clear on read
    s_nxt.change = (rd_clr ? 8'h00 : s_r.change) | ev;
    // timer restarts on each new assertion
    if (irq_new || s_r.irq_n) begin
      s_nxt.tick = '0;
      s_nxt.ms_cnt = 6'h00;
    end else if (s_r.tick == TKS_TICK_W'(TICK_CYCLES - 1)) begin
      s_nxt.tick = '0;
      s_nxt.ms_cnt = 6'(s_r.ms_cnt + 6'h01);
    end else begin
      s_nxt.tick = TKS_TICK_W'(s_r.tick + 1'b1);
    end
    // low on events, high after read or auto clear
    if (|ev) begin
      s_nxt.irq_n = 1'b0;
    end else if (rd_clr || auto_rel) begin
      s_nxt.irq_n = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: TKS_IDLE, bitcnt: 4'h0, shift: 8'h00, regaddr: 8'h00,
               rw: 1'b0, sda_oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
               addr_sel: 2'h0, strap_done: 1'b0, cfg: TKS_RST_CFG,
               chen: TKS_RST_CHEN, pressed: TKS_RST_PRESSED,
               change: TKS_RST_CHANGE, irqc: TKS_RST_IRQ, irq_n: 1'b1,
               tick: '0, ms_cnt: 6'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  hw_hold_a: assert property (!hw_shutdown_n |=> $stable(s_r.cfg) &&
    $stable(s_r.chen) && $stable(s_r.irqc) && $stable(s_r.pressed))
    else $error("registers changed in hardware shutdown");
  soft_sd_a: assert property (s_r.cfg[TKS_SSD_BIT] |=>
    $stable(s_r.pressed)) else $error("keys moved in software shutdown");
  chen_off_a: assert property (1'b1 |=>
    ((s_r.pressed ^ $past(s_r.pressed)) & ~$past(s_r.chen)) == 8'h00)
    else $error("disabled channel changed state");
  irq_set_a: assert property ((|ev) |=> !irq_out_n)
    else $error("interrupt missed an event");
  chg_set_a: assert property ((|ev) |=>
    (s_r.change & $past(ev)) == $past(ev)) else $error("change flag lost");
  irq_rise_a: assert property ($rose(irq_out_n) |->
    $past(rd_clr) || $past(auto_rel)) else $error("interrupt released early");
  key_pin_a: assert property ((|ev) |=>
    key_out_n == ($past(key_out_n) ^ $past(ev))) else $error("key pin wrong");
  aci_off_a: assert property (s_r.irqc[7:6] == TKS_ACI_OFF |->
    !auto_rel) else $error("auto clear while disabled");
  aci_short_a: assert property (!irq_out_n &&
    s_r.irqc[7:6] == TKS_ACI_SHORT |-> s_r.ms_cnt <= TKS_SHORT_MS)
    else $error("short auto clear overrun");
  ack_drive_a: assert property (s_r.st inside {TKS_ACK_A, TKS_ACK_R,
    TKS_ACK_W} |-> sda_oe) else $error("acknowledge not driven");
  rd_clr_a: assert property (rd_clr |=>
    s_r.change == $past(ev)) else $error("change not cleared by read");

  wr_cov_c: cover property (s_r.st == TKS_ACK_W ##1 s_r.st == TKS_WDATA);
  rd_cov_c: cover property (rd_clr ##1 irq_out_n);
  auto_cov_c: cover property (auto_rel ##1 irq_out_n);
endmodule : tks_touch_key_status_regs
`default_nettype wire

// ==== rtl/tks_pkg.sv ====
// Constants, register map and state types of the touch-key status block.
package tks_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] TKS_OFS_CFG = 8'h00;
  localparam logic [7:0] TKS_OFS_CHEN = 8'h01;
  localparam logic [7:0] TKS_OFS_PRESSED = 8'h02;
  localparam logic [7:0] TKS_OFS_CHANGE = 8'h03;
  localparam logic [7:0] TKS_OFS_IRQ = 8'h04;
  localparam logic [7:0] TKS_RST_CFG = 8'h00;
  localparam logic [7:0] TKS_RST_CHEN = 8'hff;
  localparam logic [7:0] TKS_RST_PRESSED = 8'h00;
  localparam logic [7:0] TKS_RST_CHANGE = 8'h00;
  localparam logic [7:0] TKS_RST_IRQ = 8'h00;
  localparam int TKS_SSD_BIT = 7;
  localparam int TKS_SENS_HI = 6;
  localparam int TKS_SENS_LO = 5;
  localparam int TKS_ACI_HI = 7;
  localparam int TKS_ACI_LO = 6;
  localparam logic [1:0] TKS_SENS_NORMAL = 2'h0;
  localparam logic [1:0] TKS_SENS_HIGH = 2'h1;
  localparam logic [1:0] TKS_SENS_LOW = 2'h2;
  localparam logic [1:0] TKS_ACI_OFF = 2'h0;
  localparam logic [1:0] TKS_ACI_SHORT = 2'h1;
  localparam logic [1:0] TKS_ACI_LONG = 2'h2;
  // ****************************************************************
  // Bus address and timing
  // ****************************************************************
  localparam logic [4:0] TKS_ADDR_UPPER = 5'h11;
  localparam int TKS_CLK_PERIOD_NS = 8;
  localparam int TKS_TICK_US = 1000;
  localparam int TKS_TICK_CYCLES = TKS_TICK_US * 1000 / TKS_CLK_PERIOD_NS;
  localparam int TKS_TICK_W = 17;
  localparam logic [5:0] TKS_SHORT_MS = 6'h08;
  localparam logic [5:0] TKS_LONG_MS = 6'h20;
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [3:0] {
    TKS_IDLE = 4'h0,
    TKS_ADDR = 4'h1,
    TKS_ACK_A = 4'h2,
    TKS_REG = 4'h3,
    TKS_ACK_R = 4'h4,
    TKS_WDATA = 4'h5,
    TKS_ACK_W = 4'h6,
    TKS_RDATA = 4'h7,
    TKS_RACK = 4'h8
  } tks_bus_st_t;
  typedef struct packed {
    tks_bus_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] regaddr;
    logic rw;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic [1:0] addr_sel;
    logic strap_done;
    logic [7:0] cfg;
    logic [7:0] chen;
    logic [7:0] pressed;
    logic [7:0] change;
    logic [7:0] irqc;
    logic irq_n;
    logic [TKS_TICK_W-1:0] tick;
    logic [5:0] ms_cnt;
  } tks_state_t;
endpackage : tks_pkg

// ==== verification/tks_host_model.sv ====
// Serial bus master model that reaches the touch-key registers.
`timescale 1ns/1ps
`default_nettype none
module tks_host_model
  import tks_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe,
  // Strap seen by the device
  input wire logic [1:0] addr_sel
);
  // ****************************************************************
  // Bit level
  // ****************************************************************
  initial begin
    scl_o = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic ph;
    repeat (4) @(negedge sys_clk);
  endtask : ph
  // Data moves a full phase after the clock falls, so no false start.
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    ph();
    scl_o = 1'b1;
    ph();
    r = sda_i;
    scl_o = 1'b0;
    ph();
  endtask : bit_io
  // bytes go most significant bit first
  task automatic byte_io(input logic [7:0] d, input logic a,
                         output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(a, ack);
  endtask : byte_io
  // also serves as the repeated start
  task automatic start;
    sda_oe = 1'b0;
    ph();
    scl_o = 1'b1;
    ph();
    sda_oe = 1'b1;
    ph();
    scl_o = 1'b0;
    ph();
  endtask : start
  task automatic stop;
    sda_oe = 1'b1;
    ph();
    scl_o = 1'b1;
    ph();
    sda_oe = 1'b0;
    ph();
  endtask : stop
  // ****************************************************************
  // Register access
  // ****************************************************************
  // address, register byte, data byte, each acknowledged
  task automatic wr(input logic [7:0] ra, input logic [7:0] d,
                    output logic nak);
    logic [7:0] r;
    logic a0;
    logic a1;
    logic a2;
    // the invalid field codes are never sent
    if (ra === TKS_OFS_CFG && d[6:5] === 2'h3) d[6] = 1'b0;
    if (ra === TKS_OFS_IRQ && d[7:6] === 2'h3) d[7] = 1'b0;
    start();
    byte_io({TKS_ADDR_UPPER, addr_sel, 1'b0}, 1'b1, r, a0);
    byte_io(ra, 1'b1, r, a1);
    byte_io(d, 1'b1, r, a2);
    stop();
    nak = a0 | a1 | a2;
  endtask : wr
  // write address and register, restart, read one byte
  task automatic rd(input logic [7:0] ra, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    start();
    byte_io({TKS_ADDR_UPPER, addr_sel, 1'b0}, 1'b1, r, a);
    byte_io(ra, 1'b1, r, a);
    start();
    byte_io({TKS_ADDR_UPPER, addr_sel, 1'b1}, 1'b1, r, a);
    byte_io(8'hff, 1'b1, d, a);
    stop();
  endtask : rd
endmodule : tks_host_model
`default_nettype wire

// ==== verification/tks_touch_key_status_regs_test.sv ====
// Self-checking testbench of the touch-key status block.
`timescale 1ns/1ps
`default_nettype none
module tks_touch_key_status_regs_test;
  import tks_pkg::*;
  localparam int TC = 4;
  logic sys_clk, rstn, hw_shutdown_n, dev_oe, host_oe, scl, irq_out_n, nak;
  logic dev_o;
  logic [7:0] key_raw, ch_active, key_out_n, d;
  logic [1:0] sens_sel;
  // The device level counts only while it drives, so a stuck-high data
  // output would cost every acknowledge.
  wire sda_line = ~host_oe & (~dev_oe | dev_o);
  int failures = 0;
  int compares = 0;
  tks_touch_key_status_regs #(.TICK_CYCLES(TC)) u_tks_touch_key_status_regs (
    .sys_clk(sys_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_line),
    .sda_o(dev_o), .sda_oe(dev_oe), .addr_sel(2'h2),
    .hw_shutdown_n(hw_shutdown_n), .key_raw(key_raw), .sens_sel(sens_sel),
    .ch_active(ch_active), .irq_out_n(irq_out_n), .key_out_n(key_out_n));
  tks_host_model u_tks_host_model (.sys_clk(sys_clk), .sda_i(sda_line),
    .scl_o(scl), .sda_oe(host_oe), .addr_sel(2'h2));
  always #4 sys_clk = ~sys_clk;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] ra, input logic [7:0] exp);
    u_tks_host_model.rd(ra, d);
    chk(d, exp, "register read");
  endtask : rdc
  task automatic wr(input logic [7:0] ra, input logic [7:0] v);
    u_tks_host_model.wr(ra, v, nak);
    chk({7'h00, nak}, 8'h00, "write acknowledge");
  endtask : wr
  task automatic keys(input logic [7:0] k);
    key_raw = k;
    repeat (3) @(negedge sys_clk);
  endtask : keys
  task automatic end_sim;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(key_out_n, 8'hff, "keys idle");
    chk({7'h00, irq_out_n}, 8'h01, "irq idle");
    rdc(TKS_OFS_CFG, TKS_RST_CFG);
    rdc(TKS_OFS_CHEN, TKS_RST_CHEN);
    rdc(TKS_OFS_PRESSED, TKS_RST_PRESSED);
    rdc(TKS_OFS_CHANGE, TKS_RST_CHANGE);
    rdc(TKS_OFS_IRQ, TKS_RST_IRQ);
  endtask : t_reset
  task automatic t_regs;
    wr(TKS_OFS_CFG, 8'h3f);
    chk({6'h00, sens_sel}, {6'h00, TKS_SENS_HIGH}, "sens high");
    rdc(TKS_OFS_CFG, 8'h20);
    wr(TKS_OFS_CFG, 8'h40);
    chk({6'h00, sens_sel}, {6'h00, TKS_SENS_LOW}, "sens low");
    wr(TKS_OFS_CFG, 8'h00);
    wr(TKS_OFS_CHEN, 8'h5a);
    chk(ch_active, 8'h5a, "channel gate");
    rdc(TKS_OFS_CHEN, 8'h5a);
    wr(TKS_OFS_CHEN, 8'hff);
    wr(TKS_OFS_PRESSED, 8'hff);
    rdc(TKS_OFS_PRESSED, 8'h00);
    rdc(8'h05, 8'h00);
    wr(TKS_OFS_IRQ, 8'hbf);
    rdc(TKS_OFS_IRQ, 8'h80);
    wr(TKS_OFS_IRQ, 8'h00);
  endtask : t_regs
  task automatic t_keys;
    keys(8'h81);
    chk(key_out_n, 8'h7e, "key outputs");
    chk({7'h00, irq_out_n}, 8'h00, "irq on press");
    rdc(TKS_OFS_PRESSED, 8'h81);
    rdc(TKS_OFS_CHANGE, 8'h81);
    chk({7'h00, irq_out_n}, 8'h01, "irq after read");
    rdc(TKS_OFS_CHANGE, 8'h00);
    keys(8'h01);
    chk({7'h00, irq_out_n}, 8'h00, "irq on release");
    rdc(TKS_OFS_CHANGE, 8'h80);
    keys(8'h00);
    rdc(TKS_OFS_CHANGE, 8'h01);
    wr(TKS_OFS_CHEN, 8'hfd);
    keys(8'h02);
    chk({7'h00, irq_out_n}, 8'h01, "disabled silent");
    rdc(TKS_OFS_PRESSED, 8'h00);
    keys(8'h00);
    wr(TKS_OFS_CHEN, 8'hff);
  endtask : t_keys
  task automatic t_shut;
    wr(TKS_OFS_CFG, 8'h80);
    chk(ch_active, 8'h00, "soft shutdown");
    keys(8'h10);
    chk({7'h00, irq_out_n}, 8'h01, "frozen soft");
    rdc(TKS_OFS_CHEN, 8'hff);
    keys(8'h00);
    wr(TKS_OFS_CFG, 8'h00);
    hw_shutdown_n = 1'b0;
    keys(8'h10);
    chk(ch_active, 8'h00, "hard shutdown");
    chk(key_out_n, 8'hff, "frozen hard");
    wr(TKS_OFS_CHEN, 8'h00);
    rdc(TKS_OFS_CHEN, 8'hff);
    keys(8'h00);
    hw_shutdown_n = 1'b1;
  endtask : t_shut
  task automatic t_auto;
    int n;
    int e;
    for (int k = 1; k <= 2; k++) begin
      wr(TKS_OFS_IRQ, {k[1:0], 6'h00});
      keys(key_raw ^ 8'h04);
      e = (k == 1) ? 8 * TC : 32 * TC;
      n = 3;
      while (irq_out_n !== 1'b1 && n < 400) begin
        @(negedge sys_clk);
        n++;
      end
      compares++;
      // release lands after the chosen number of ticks
      if (n < e - 2 || n > e + 3) begin
        failures++;
        $display("CHECK FAILED at %0t: auto clear after %0d", $time, n);
      end
      rdc(TKS_OFS_CHANGE, 8'h04);
    end
    wr(TKS_OFS_IRQ, 8'h00);
    // The second pass left the key released, so press it for a new event.
    keys(8'h04);
    repeat (40 * TC) @(negedge sys_clk);
    chk({7'h00, irq_out_n}, 8'h00, "no auto clear");
    rdc(TKS_OFS_CHANGE, 8'h04);
  endtask : t_auto
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    hw_shutdown_n = 1'b1;
    key_raw = 8'h00;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_reset();
    t_regs();
    t_keys();
    t_shut();
    t_auto();
    end_sim();
  end
  initial begin
    #500000;
    failures++;
    end_sim();
  end
endmodule : tks_touch_key_status_regs_test
`default_nettype wire
